// *** rtl/fpxd_pkg.sv ***
`default_nettype none
package fpxd_pkg;
  // instruction field positions
  localparam int OPC_LSB = 26;
  localparam int FMT_LSB = 21;
  localparam int SRC2_LSB = 16;
  localparam int SRC1_LSB = 11;
  localparam int DEST_LSB = 6;
  // major opcode of the float coprocessor
  localparam logic [5:0] OPC_FLOAT = 6'h11;
  // format field codes
  localparam logic [4:0] FMT_SINGLE = 5'h10;
  localparam logic [4:0] FMT_DOUBLE = 5'h11;
  localparam logic [4:0] FMT_WORD = 5'h14;
  localparam logic [4:0] FMT_LONG = 5'h15;
  localparam logic [4:0] FMT_PAIRED = 5'h16;
  localparam logic [4:0] FMT_ANY_TWO = 5'h09;
  localparam logic [4:0] FMT_ANY_FOUR = 5'h0A;
  // function rows (bits 5..3)
  localparam logic [2:0] ROW_ARITH = 3'h3;
  localparam logic [2:0] ROW_CONVERT = 3'h4;
  localparam logic [2:0] ROW_PAIR_MOVE = 3'h5;
  localparam logic [1:0] ROW_COMPARE_HI = 2'h3;
  // function columns (bits 2..0)
  localparam logic [2:0] COL_RED_ADD = 3'h0;
  localparam logic [2:0] COL_RED_MUL = 3'h2;
  localparam logic [2:0] COL_INT_TO_FLOAT = 3'h6;
  localparam logic [2:0] COL_FLOAT_TO_INT = 3'h4;
  // rounding mode codes of the control/status register
  localparam logic [1:0] RM_NEAR = 2'h0;
  localparam logic [1:0] RM_ZERO = 2'h1;
  localparam logic [1:0] RM_UP = 2'h2;
  localparam logic [1:0] RM_DOWN = 2'h3;
  // cause bit positions
  localparam int CB_INEXACT = 0;
  localparam int CB_UNDER = 1;
  localparam int CB_OVER = 2;
  localparam int CB_DIVZ = 3;
  localparam int CB_INVALID = 4;
  localparam int CB_UNIMPL = 5;
  // reset values and fixed results
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [31:0] DEFAULT_QNAN = 32'h7FC0_0000;
  localparam logic [31:0] MAX_FINITE = 32'h7F7F_FFFF;
  localparam int QUIET_BIT = 22;
  // decoded operation kinds
  typedef enum logic [3:0] {
    OP_NONE, OP_RED_ADD, OP_RED_MUL, OP_RCP_ONE, OP_RCP_TWO, OP_ISQ_ONE, OP_ISQ_TWO,
    OP_INT_TO_FLOAT, OP_FLOAT_TO_INT, OP_PAIR_LOW_LOW, OP_PAIR_LOW_HIGH,
    OP_PAIR_HIGH_LOW, OP_PAIR_HIGH_HIGH, OP_MAG_CMP, OP_BR_ANY_TWO, OP_BR_ANY_FOUR
  } fpxd_op_t;
endpackage
`default_nettype wire

// *** rtl/fpxd_add_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface fpxd_add_if;
  logic [31:0] opnd_a; // first addend
  logic [31:0] opnd_b; // second addend
  logic [1:0] rmode; // rounding mode
  logic [31:0] sum; // rounded sum
  logic [5:0] cause; // exception causes
  modport core(input opnd_a, opnd_b, rmode, output sum, cause);
  modport user(output opnd_a, opnd_b, rmode, input sum, cause);
endinterface
`default_nettype wire

// *** rtl/fpxd_sp_add.sv ***
`timescale 1ns/1ps
`default_nettype none
module fpxd_sp_add import fpxd_pkg::*; (
  // adder operands and answer
  fpxd_add_if.core port_add
);
  // position of the leading one counted from bit 26
  function automatic logic [4:0] lead_zeros(input logic [26:0] v);
    lead_zeros = 5'h00;
    for (int i = 0; i < 27; i++) begin
      if (v[i]) lead_zeros = 5'(26 - i);
    end
  endfunction

  // single-precision add, exact then rounded once
  always_comb begin
    logic [31:0] a, b, big, sml;
    logic [26:0] mb, ms, al;
    logic [7:0] d;
    logic [27:0] s;
    logic signed [9:0] e;
    logic [24:0] man;
    logic sub, sgn, inc, a_nan, b_nan, snan, a_inf, b_inf, a_den, b_den, a_zero, b_zero;
    a = port_add.opnd_a;
    b = port_add.opnd_b;
    a_nan = (&a[30:23]) && (|a[22:0]);
    b_nan = (&b[30:23]) && (|b[22:0]);
    snan = (a_nan && !a[QUIET_BIT]) || (b_nan && !b[QUIET_BIT]);
    a_inf = (&a[30:23]) && !(|a[22:0]);
    b_inf = (&b[30:23]) && !(|b[22:0]);
    a_zero = (a[30:0] == 31'h0000_0000);
    b_zero = (b[30:0] == 31'h0000_0000);
    a_den = (a[30:23] == 8'h00) && !a_zero;
    b_den = (b[30:23] == 8'h00) && !b_zero;
    // larger magnitude goes first
    big = (a[30:0] < b[30:0]) ? b : a;
    sml = (a[30:0] < b[30:0]) ? a : b;
    mb = {1'b1, big[22:0], 3'h0};
    ms = {1'b1, sml[22:0], 3'h0};
    d = big[30:23] - sml[30:23];
    // alignment keeps a sticky bit so nothing is lost
    al = (d > 8'h1A) ? 27'h000_0001 :
         ((ms >> d) | {26'h000_0000, |(ms & ((27'h000_0001 << d) - 27'h000_0001))});
    sub = big[31] ^ sml[31];
    sgn = big[31];
    s = sub ? ({1'b0, mb} - {1'b0, al}) : ({1'b0, mb} + {1'b0, al});
    e = $signed({2'h0, big[30:23]});
    man = 25'h000_0000;
    inc = 1'b0;
    port_add.sum = 32'h0000_0000;
    port_add.cause = 6'h00;
    if (a_nan || b_nan) begin
      // quiet result, invalid only for a signalling operand
      port_add.sum = DEFAULT_QNAN;
      port_add.cause[CB_INVALID] = snan;
    end else if (a_inf && b_inf && (a[31] != b[31])) begin
      port_add.sum = DEFAULT_QNAN;
      port_add.cause[CB_INVALID] = 1'b1;
    end else if (a_inf || b_inf) begin
      port_add.sum = a_inf ? a : b;
    end else if (a_den || b_den) begin
      // subnormal operands are left to software
      port_add.cause[CB_UNIMPL] = 1'b1;
    end else if (a_zero && b_zero) begin
      port_add.sum = {(a[31] == b[31]) ? a[31] : (port_add.rmode == RM_DOWN), 31'h0000_0000};
    end else if (a_zero || b_zero) begin
      port_add.sum = a_zero ? b : a;
    end else if (s == 28'h000_0000) begin
      // exact cancellation: sign follows the rounding mode
      port_add.sum = {port_add.rmode == RM_DOWN, 31'h0000_0000};
    end else begin
      // normalise
      if (s[27]) begin
        s = {1'b0, s[27:2], s[1] | s[0]};
        e = e + 10'sd1;
      end else begin
        e = e - $signed({5'h00, lead_zeros(s[26:0])});
        s = s << lead_zeros(s[26:0]);
      end
      // round by the selected mode
      unique case (port_add.rmode)
        RM_NEAR: inc = s[2] & (s[1] | s[0] | s[3]);
        RM_ZERO: inc = 1'b0;
        RM_UP: inc = !sgn && (|s[2:0]);
        RM_DOWN: inc = sgn && (|s[2:0]);
      endcase
      man = {1'b0, s[26:3]} + {24'h00_0000, inc};
      if (man[24]) begin
        man = man >> 1;
        e = e + 10'sd1;
      end
      port_add.cause[CB_INEXACT] = |s[2:0];
      if (e >= 10'sd255) begin
        // overflow: infinity or largest finite per mode
        port_add.cause[CB_OVER] = 1'b1;
        port_add.cause[CB_INEXACT] = 1'b1;
        if (port_add.rmode == RM_NEAR || (port_add.rmode == RM_UP && !sgn) ||
            (port_add.rmode == RM_DOWN && sgn)) begin
          port_add.sum = {sgn, 31'h7F80_0000};
        end else begin
          port_add.sum = {sgn, MAX_FINITE[30:0]};
        end
      end else if (e <= 10'sd0) begin
        // tiny result is left to software
        port_add.cause[CB_UNDER] = 1'b1;
        port_add.cause[CB_UNIMPL] = 1'b1;
      end else begin
        port_add.sum = {sgn, e[7:0], man[22:0]};
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/fpxd_decoder.sv ***
// Overview of operation
// - single: steps in row 3, compares rows 6-7
// - double uses the same positions as single
// - word/long: only int pair to float pair
// - paired map: adds, moves, conversions, compares
// - reduction add opcode, format, function, register fields
// - second source halves summed into lower half
// - first source halves summed into upper half
// - exact sums rounded by current rounding mode
// - both additions' exceptions are ORed together
// - causes ORed into sticky flags without trap
// - unusable or reserved exception may be raised
// - unimplemented, invalid, overflow, inexact, underflow signalled
// - absent extension raises reserved instruction
// - needs 64-bit float enabled, else exception
`timescale 1ns/1ps
`default_nettype none
module fpxd_decoder import fpxd_pkg::*; #(
  parameter bit EXT_PRESENT = 1'b1
) (
  // clock, reset and enable
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  // instruction issue
  input wire logic INSTR_VALID,
  input wire logic [31:0] INSTR,
  input wire logic [63:0] SRC1_DATA,
  input wire logic [63:0] SRC2_DATA,
  // float unit state
  input wire logic FP64_EN,
  input wire logic COP_USABLE,
  input wire logic [1:0] ROUND_MODE,
  input wire logic [4:0] TRAP_EN,
  input wire logic [4:0] FLAG_CLR,
  // decode answer
  output fpxd_op_t OP_KIND,
  output logic [3:0] CMP_COND,
  output logic EXT_HIT,
  output logic PASS_BASE,
  output logic RSVD_EXC,
  output logic UNUSABLE_EXC,
  // reduction add answer
  output logic RES_VALID,
  output logic [63:0] RES_DATA,
  output logic [4:0] RES_DEST,
  output logic [5:0] CAUSE,
  output logic FP_TRAP,
  output logic [4:0] FLAGS
);
  // instruction fields
  logic [5:0] opc;
  logic [4:0] fmt;
  logic [2:0] row;
  logic [2:0] col;
  assign opc = INSTR[OPC_LSB +: 6];
  assign fmt = INSTR[FMT_LSB +: 5];
  assign row = INSTR[5:3];
  assign col = INSTR[2:0];

  fpxd_op_t next_op; // decoded kind this cycle
  logic [3:0] next_cond; // compare condition
  logic hit; // extension code recognised
  logic radd_go; // reduction add will execute
  logic [5:0] cause_all; // merged causes
  logic trap; // enabled exception present

  // reciprocal / inverse-root column map, shared by all float formats
  function automatic fpxd_op_t step_op(input logic [2:0] c);
    unique case (c[1:0])
      2'h0: step_op = OP_RCP_TWO;
      2'h1: step_op = OP_RCP_ONE;
      2'h2: step_op = OP_ISQ_ONE;
      2'h3: step_op = OP_ISQ_TWO;
    endcase
  endfunction

  // function field decode per format
  always_comb begin
    next_op = OP_NONE;
    next_cond = {row[0], col};
    if (opc == OPC_FLOAT) begin
      case (fmt)
        FMT_SINGLE, FMT_DOUBLE: begin
          if (row == ROW_ARITH && col[2]) next_op = step_op(col);
          else if (row[2:1] == ROW_COMPARE_HI) next_op = OP_MAG_CMP;
        end
        FMT_WORD, FMT_LONG: begin
          if (row == ROW_CONVERT && col == COL_INT_TO_FLOAT) begin
            next_op = OP_INT_TO_FLOAT;
          end
        end
        FMT_PAIRED: begin
          if (row == ROW_ARITH && col[2]) next_op = step_op(col);
          else if (row == ROW_ARITH && col == COL_RED_ADD) next_op = OP_RED_ADD;
          else if (row == ROW_ARITH && col == COL_RED_MUL) next_op = OP_RED_MUL;
          else if (row == ROW_CONVERT && col == COL_FLOAT_TO_INT) next_op = OP_FLOAT_TO_INT;
          else if (row == ROW_PAIR_MOVE && col[2]) begin
            // pair moves by the low column bits
            unique case (col[1:0])
              2'h0: next_op = OP_PAIR_LOW_LOW;
              2'h1: next_op = OP_PAIR_LOW_HIGH;
              2'h2: next_op = OP_PAIR_HIGH_LOW;
              2'h3: next_op = OP_PAIR_HIGH_HIGH;
            endcase
          end else if (row[2:1] == ROW_COMPARE_HI) next_op = OP_MAG_CMP;
        end
        FMT_ANY_TWO: next_op = OP_BR_ANY_TWO;
        FMT_ANY_FOUR: next_op = OP_BR_ANY_FOUR;
        default: next_op = OP_NONE; // empty cells stay with the base decoder
      endcase
    end
  end
  assign hit = INSTR_VALID && (next_op != OP_NONE);

  // decode answer, one cycle after issue
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      OP_KIND <= OP_NONE;
      CMP_COND <= 4'h0;
      EXT_HIT <= 1'b0;
      PASS_BASE <= 1'b0;
      RSVD_EXC <= 1'b0;
      UNUSABLE_EXC <= 1'b0;
    end else if (CLK_EN) begin
      OP_KIND <= hit ? next_op : OP_NONE;
      CMP_COND <= (hit && next_op == OP_MAG_CMP) ? next_cond : 4'h0;
      EXT_HIT <= hit && EXT_PRESENT && COP_USABLE && FP64_EN;
      PASS_BASE <= INSTR_VALID && !hit;
      // coprocessor access first, then extension and 64-bit gating
      UNUSABLE_EXC <= hit && !COP_USABLE;
      RSVD_EXC <= hit && COP_USABLE && (!EXT_PRESENT || !FP64_EN);
    end
  end

  // two independent adders: second source to lower, first source to upper
  fpxd_add_if add_lo();
  fpxd_add_if add_hi();
  assign add_lo.opnd_a = SRC2_DATA[63:32];
  assign add_lo.opnd_b = SRC2_DATA[31:0];
  assign add_lo.rmode = ROUND_MODE;
  assign add_hi.opnd_a = SRC1_DATA[63:32];
  assign add_hi.opnd_b = SRC1_DATA[31:0];
  assign add_hi.rmode = ROUND_MODE;
  fpxd_sp_add u_add_lo (.port_add(add_lo.core));
  fpxd_sp_add u_add_hi (.port_add(add_hi.core));

  // result only for a legal, permitted issue
  assign radd_go = hit && next_op == OP_RED_ADD && EXT_PRESENT && COP_USABLE && FP64_EN;
  assign cause_all = add_lo.cause | add_hi.cause;
  // unimplemented always traps, others by enable
  assign trap = |(cause_all & {1'b1, TRAP_EN});

  // reduction add result and causes
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RES_VALID <= 1'b0;
      RES_DATA <= 64'h0000_0000_0000_0000;
      RES_DEST <= 5'h00;
      CAUSE <= 6'h00;
      FP_TRAP <= 1'b0;
    end else if (CLK_EN) begin
      RES_VALID <= radd_go && !trap;
      FP_TRAP <= radd_go && trap;
      if (radd_go) begin
        RES_DATA <= {add_hi.sum, add_lo.sum};
        RES_DEST <= INSTR[DEST_LSB +: 5];
        CAUSE <= cause_all;
      end
    end
  end

  // sticky flags: a new cause wins over a clear in the same cycle
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      FLAGS <= FLAGS_RESET;
    end else if (CLK_EN) begin
      FLAGS <= (FLAGS & ~FLAG_CLR) | ((radd_go && !trap) ? cause_all[4:0] : 5'h00);
    end
  end

  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_radd_issue;
    CLK_EN && radd_go && !trap;
  endsequence
  sequence s_radd_trap;
    CLK_EN && radd_go && trap;
  endsequence

  chk_radd_decode: assert property (CLK_EN && INSTR_VALID && opc == OPC_FLOAT &&
      fmt == FMT_PAIRED && INSTR[5:0] == 6'h18 |=> OP_KIND == OP_RED_ADD)
    else $error("reduction add not decoded");
  chk_single_step: assert property (CLK_EN && INSTR_VALID && opc == OPC_FLOAT &&
      fmt == FMT_SINGLE && INSTR[5:0] == 6'h1C |=> OP_KIND == OP_RCP_TWO)
    else $error("single reciprocal step two misplaced");
  chk_double_cmp: assert property (CLK_EN && INSTR_VALID && opc == OPC_FLOAT &&
      fmt == FMT_DOUBLE && row[2:1] == 2'h3 |=> OP_KIND == OP_MAG_CMP &&
      CMP_COND == {$past(row[0]), $past(col)})
    else $error("double compare misdecoded");
  chk_word_only: assert property (CLK_EN && INSTR_VALID && opc == OPC_FLOAT &&
      fmt == FMT_WORD && INSTR[5:0] != 6'h26 |=> OP_KIND == OP_NONE && PASS_BASE)
    else $error("word format decoded extra function");
  chk_pair_move: assert property (CLK_EN && INSTR_VALID && opc == OPC_FLOAT &&
      fmt == FMT_PAIRED && INSTR[5:0] == 6'h2F |=> OP_KIND == OP_PAIR_HIGH_HIGH)
    else $error("pair move high high misdecoded");
  chk_lower_sum: assert property (s_radd_issue |=> RES_VALID &&
      RES_DATA[31:0] == $past(add_lo.sum))
    else $error("lower half not second source sum");
  chk_upper_sum: assert property (s_radd_issue |=>
      RES_DATA[63:32] == $past(add_hi.sum) && RES_DEST == $past(INSTR[10:6]))
    else $error("upper half or destination wrong");
  chk_cause_merge: assert property (CLK_EN && radd_go |=>
      CAUSE == ($past(add_lo.cause) | $past(add_hi.cause)))
    else $error("causes not merged");
  chk_flag_sticky: assert property (s_radd_issue |=>
      (FLAGS & $past(cause_all[4:0])) == $past(cause_all[4:0]))
    else $error("cause not folded into flags");
  chk_trap_quiet: assert property (s_radd_trap |=> FP_TRAP && !RES_VALID &&
      FLAGS == ($past(FLAGS) & ~$past(FLAG_CLR)))
    else $error("trapped add changed flags or result");
  chk_unusable: assert property (CLK_EN && hit && !COP_USABLE |=>
      UNUSABLE_EXC && !RSVD_EXC && !EXT_HIT)
    else $error("unusable exception missing");
  chk_fp64_gate: assert property (CLK_EN && hit && COP_USABLE && !FP64_EN |=>
      RSVD_EXC && !RES_VALID)
    else $error("reserved exception missing without 64-bit float");
endmodule
`default_nettype wire

// *** verification/fpxd_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// behavioural core pipeline: drives the issue lanes at the falling edge
module fpxd_core_model import fpxd_pkg::*; (
  // bench clock
  input wire logic clk,
  // issue lanes
  output logic instr_valid,
  output logic [31:0] instr,
  output logic [63:0] src1_data,
  output logic [63:0] src2_data,
  // float unit state
  output logic fp64_en,
  output logic cop_usable,
  output logic [1:0] round_mode,
  output logic [4:0] trap_en,
  output logic [4:0] flag_clr
);
  // idle lanes and default mode at time zero
  initial begin
    instr_valid = 1'b0;
    instr = 32'h0000_0000;
    src1_data = 64'h0000_0000_0000_0000;
    src2_data = 64'h0000_0000_0000_0000;
    fp64_en = 1'b1;
    cop_usable = 1'b1;
    round_mode = RM_NEAR;
    trap_en = 5'h00;
    flag_clr = 5'h00;
  end
  // one issue cycle; registers and operands are legal paired values, full register mode
  task automatic issue(input logic [31:0] word, input logic [63:0] a, input logic [63:0] b);
    @(negedge clk);
    instr_valid <= 1'b1;
    instr <= word;
    src1_data <= a;
    src2_data <= b;
    @(negedge clk);
    instr_valid <= 1'b0;
    // released lanes show the inverse so a stale word never passes
    instr <= ~word;
    src1_data <= ~a;
    src2_data <= ~b;
  endtask
  // float unit mode bits
  task automatic set_mode(input logic fp64, input logic usable,
                          input logic [1:0] rm, input logic [4:0] trap);
    @(negedge clk);
    fp64_en <= fp64;
    cop_usable <= usable;
    round_mode <= rm;
    trap_en <= trap;
  endtask
  // one-cycle clear of sticky flags
  task automatic clear(input logic [4:0] mask);
    @(negedge clk);
    flag_clr <= mask;
    @(negedge clk);
    flag_clr <= 5'h00;
  endtask
endmodule
`default_nettype wire

// *** verification/fp_extension_decoder_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module fp_extension_decoder_tb import fpxd_pkg::*;;
  // reduction add word: second source 3, first source 4, destination 11
  localparam logic [31:0] ADD_WORD = {OPC_FLOAT, FMT_PAIRED, 5'h03, 5'h04, 5'h0B, 6'h18};
  // operand pairs that sit exactly on a rounding tie
  localparam logic [63:0] NEG_TIE = 64'hBF80_0000_B380_0000;
  localparam logic [63:0] POS_TIE = 64'h3F80_0000_3380_0000;
  // infinities of both signs and the largest finite pair
  localparam logic [63:0] INF_PAIR = 64'h7F80_0000_FF80_0000;
  localparam logic [63:0] MAX_PAIR = {MAX_FINITE, MAX_FINITE};
  // clock, reset, enable
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  // issue lanes and unit state
  logic instr_valid;
  logic [31:0] instr;
  logic [63:0] src1_data;
  logic [63:0] src2_data;
  logic fp64_en;
  logic cop_usable;
  logic [1:0] round_mode;
  logic [4:0] trap_en;
  logic [4:0] flag_clr;
  // decoder answers
  fpxd_op_t op_kind;
  logic [3:0] cmp_cond;
  logic ext_hit;
  logic pass_base;
  logic rsvd_exc;
  logic unusable_exc;
  logic res_valid;
  logic [63:0] res_data;
  logic [4:0] res_dest;
  logic [5:0] cause;
  logic fp_trap;
  logic [4:0] flags;
  // bookkeeping
  int error_cnt = 0;
  int n_tests = 0;
  logic [4:0] exp_flags = 5'h00;
  logic [4:0] fmt;
  // expected upper and lower sums per rounding mode
  logic [31:0] up_tab [4] = '{32'hBF80_0000, 32'hBF80_0000, 32'hBF80_0000, 32'hBF80_0001};
  logic [31:0] lo_tab [4] = '{32'h3F80_0000, 32'h3F80_0000, 32'h3F80_0001, 32'h3F80_0000};
  // 100 ns clock
  always #50 ref_clk = ~ref_clk;
  // pipeline model
  fpxd_core_model core (.clk(ref_clk), .instr_valid(instr_valid), .instr(instr),
    .src1_data(src1_data), .src2_data(src2_data), .fp64_en(fp64_en),
    .cop_usable(cop_usable), .round_mode(round_mode), .trap_en(trap_en), .flag_clr(flag_clr));
  // block under test
  fpxd_decoder DUT (.REF_CLK(ref_clk), .RST_N(rst_n), .CLK_EN(clk_en),
    .INSTR_VALID(instr_valid), .INSTR(instr), .SRC1_DATA(src1_data), .SRC2_DATA(src2_data),
    .FP64_EN(fp64_en), .COP_USABLE(cop_usable), .ROUND_MODE(round_mode), .TRAP_EN(trap_en),
    .FLAG_CLR(flag_clr), .OP_KIND(op_kind), .CMP_COND(cmp_cond), .EXT_HIT(ext_hit),
    .PASS_BASE(pass_base), .RSVD_EXC(rsvd_exc), .UNUSABLE_EXC(unusable_exc),
    .RES_VALID(res_valid), .RES_DATA(res_data), .RES_DEST(res_dest), .CAUSE(cause),
    .FP_TRAP(fp_trap), .FLAGS(flags));
  // vector compare
  task automatic cmp_val(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // decoded kind compare
  task automatic cmp_op(input fpxd_op_t got, input fpxd_op_t exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // end-of-test note
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask
  // issue one code and check its placement
  task automatic dec(input logic [4:0] f, input logic [5:0] fn, input fpxd_op_t op,
                     input logic [3:0] cond);
    core.issue({OPC_FLOAT, f, 15'h0000, fn}, 64'h0, 64'h0);
    cmp_op(op_kind, op);
    cmp_val(cmp_cond, cond);
    cmp_val(ext_hit, op != OP_NONE);
    cmp_val(pass_base, op == OP_NONE);
  endtask
  // reduction add refused by mode
  task automatic exc(input logic rsvd, input logic unusable);
    core.issue(ADD_WORD, POS_TIE, POS_TIE);
    cmp_val(rsvd_exc, rsvd);
    cmp_val(unusable_exc, unusable);
    cmp_val(ext_hit | res_valid, 1'b0);
    cmp_val(flags, exp_flags);
  endtask
  // reduction add with full result check
  task automatic do_add(input logic [63:0] a, input logic [63:0] b, input logic [63:0] res,
                        input logic [5:0] cs, input logic trap);
    core.issue(ADD_WORD, a, b);
    cmp_op(op_kind, OP_RED_ADD);
    cmp_val(res_valid, !trap);
    cmp_val(fp_trap, trap);
    cmp_val(cause, cs);
    cmp_val(res_data, res);
    if (!trap) begin
      exp_flags = exp_flags | cs[4:0];
      cmp_val(res_dest, 5'h0B);
    end
    cmp_val(flags, exp_flags);
  endtask
  // closing verdict
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog, far beyond the expected run
  initial begin
    #200_000;
    error_cnt++;
    print_verdict();
  end
  // main sequence
  initial begin
    repeat (6) @(negedge ref_clk);
    cmp_op(op_kind, OP_NONE);
    cmp_val(flags, 5'h00);
    rst_n = 1'b1;
    end_test("reset");
    // steps and compares share positions in single, double and paired
    for (int i = 0; i < 3; i++) begin
      fmt = (i == 0) ? FMT_SINGLE : (i == 1) ? FMT_DOUBLE : FMT_PAIRED;
      dec(fmt, 6'h1C, OP_RCP_TWO, 4'h0);
      dec(fmt, 6'h1D, OP_RCP_ONE, 4'h0);
      dec(fmt, 6'h1E, OP_ISQ_ONE, 4'h0);
      dec(fmt, 6'h1F, OP_ISQ_TWO, 4'h0);
      for (int c = 0; c < 16; c++) begin
        dec(fmt, 6'h30 + 6'(c), OP_MAG_CMP, 4'(c));
      end
    end
    dec(FMT_SINGLE, 6'h18, OP_NONE, 4'h0);
    dec(FMT_DOUBLE, 6'h24, OP_NONE, 4'h0);
    dec(FMT_WORD, 6'h26, OP_INT_TO_FLOAT, 4'h0);
    dec(FMT_LONG, 6'h26, OP_INT_TO_FLOAT, 4'h0);
    dec(FMT_WORD, 6'h1C, OP_NONE, 4'h0);
    dec(FMT_LONG, 6'h24, OP_NONE, 4'h0);
    dec(FMT_PAIRED, 6'h18, OP_RED_ADD, 4'h0);
    dec(FMT_PAIRED, 6'h1A, OP_RED_MUL, 4'h0);
    dec(FMT_PAIRED, 6'h24, OP_FLOAT_TO_INT, 4'h0);
    dec(FMT_PAIRED, 6'h2C, OP_PAIR_LOW_LOW, 4'h0);
    dec(FMT_PAIRED, 6'h2D, OP_PAIR_LOW_HIGH, 4'h0);
    dec(FMT_PAIRED, 6'h2E, OP_PAIR_HIGH_LOW, 4'h0);
    dec(FMT_PAIRED, 6'h2F, OP_PAIR_HIGH_HIGH, 4'h0);
    dec(FMT_PAIRED, 6'h19, OP_NONE, 4'h0);
    dec(FMT_PAIRED, 6'h26, OP_NONE, 4'h0);
    dec(FMT_ANY_TWO, 6'h00, OP_BR_ANY_TWO, 4'h0);
    dec(FMT_ANY_FOUR, 6'h00, OP_BR_ANY_FOUR, 4'h0);
    end_test("decode map");
    // enable low freezes every output, pulses included
    clk_en = 1'b0;
    core.issue(ADD_WORD, POS_TIE, POS_TIE);
    cmp_op(op_kind, OP_BR_ANY_FOUR);
    cmp_val({ext_hit, res_valid, flags}, 7'h40);
    clk_en = 1'b1;
    end_test("clock enable");
    // refused modes, unusable wins over reserved
    core.set_mode(1'b0, 1'b1, RM_NEAR, 5'h00);
    exc(1'b1, 1'b0);
    core.set_mode(1'b0, 1'b0, RM_NEAR, 5'h00);
    exc(1'b0, 1'b1);
    core.set_mode(1'b1, 1'b0, RM_NEAR, 5'h00);
    exc(1'b0, 1'b1);
    core.set_mode(1'b1, 1'b1, RM_NEAR, 5'h00);
    end_test("exceptions");
    do_add(64'h3F80_0000_4000_0000, 64'h3F00_0000_3E80_0000,
           64'h4040_0000_3F40_0000, 6'h00, 1'b0);
    // tie in every rounding mode, opposite signs in the two halves
    for (int m = 0; m < 4; m++) begin
      core.set_mode(1'b1, 1'b1, 2'(m), 5'h00);
      do_add(NEG_TIE, POS_TIE, {up_tab[m], lo_tab[m]}, 6'h01, 1'b0);
    end
    core.set_mode(1'b1, 1'b1, RM_NEAR, 5'h00);
    // a new cause and its clear in one cycle: the cause wins
    fork
      core.issue(ADD_WORD, NEG_TIE, POS_TIE);
      core.clear(5'h01);
    join
    cmp_val(flags, 5'h01);
    cmp_val(res_data, {up_tab[0], lo_tab[0]});
    core.clear(5'h1F);
    exp_flags = 5'h00;
    cmp_val(flags, 5'h00);
    end_test("rounding");
    // invalid in one half, overflow in the other
    do_add(INF_PAIR, MAX_PAIR, {DEFAULT_QNAN, 32'h7F80_0000}, 6'h15,
           1'b0);
    core.clear(5'h1F);
    exp_flags = 5'h00;
    core.set_mode(1'b1, 1'b1, RM_NEAR, 5'h10);
    do_add(INF_PAIR, MAX_PAIR, {DEFAULT_QNAN, 32'h7F80_0000}, 6'h15, 1'b1);
    core.set_mode(1'b1, 1'b1, RM_NEAR, 5'h00);
    // subnormal operand always traps as unimplemented
    core.issue(ADD_WORD, 64'h0000_0001_3F80_0000, 64'h0000_0000_0000_0000);
    cmp_val(cause[CB_UNIMPL], 1'b1);
    cmp_val({fp_trap, res_valid}, 2'b10);
    cmp_val(flags, 5'h00);
    end_test("exception merge and trap");
    print_verdict();
  end
endmodule
`default_nettype wire
